// ### src/asr_pkg.sv
// Functional notes
// - clock source select high: shift clock comes from host serial clock pin.
// - with chip-select and read-enable low, read after or during conversion.
// - host clock may be continuous or gated, idling high or low; here an idle-high clock's first fall shifts past the msb.
// - after busy falls, new result shifts out msb first over 16 pulses.
// - read-after-conversion host clock may run at any rate up to 40 MHz; here each clock phase must last about three core periods.
// - cascading only in external-clock read-after-conversion mode via chain input.
// - chain input sampled on edge opposite shifting; upstream msb follows local lsb.
// - up to twenty converters at 100 kSPS may be cascaded.
// - during conversion, previous result shifts out msb first over 16 pulses.
// - incomplete read during conversion pulses read overrun output high.
// - outputs released whenever chip-select or read-enable is high.
// - falling convert start begins conversion; busy high until it completes.
// - serial interface used when serial-parallel select is high.
package asr_pkg;
	localparam int RESULT_BITS     = 16;
	localparam int CLK_PERIOD_NS   = 40;
	localparam int CONV_TIME_NS    = 8000;
	localparam int CONV_CYCLES     = CONV_TIME_NS / CLK_PERIOD_NS;
	localparam int SYNC_STAGES     = 2;
	localparam logic [15:0] RESULT_RESET = 16'h0000;
	localparam logic [4:0]  BITCNT_RESET = 5'h00;

	typedef struct packed {
		logic serial_clock;
		logic chip_select_n;
		logic read_enable_n;
		logic convert_start_n;
		logic chain_input_or_read_mode;
	} asr_pins_type;

	typedef struct packed {
		logic serial_data_output;
		logic serial_data_oe;
		logic busy;
		logic read_overrun_pulse;
	} asr_outs_type;
endpackage

// ### src/asr_sync.sv
`timescale 1ns/100ps
module asr_sync #(
	parameter int WIDTH = 5
) (
	input  wire logic             core_clk,
	input  wire logic             rst,
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] stage1_ff;
	logic [WIDTH-1:0] stage2_ff;
	logic [WIDTH-1:0] nxt_stage1;
	logic [WIDTH-1:0] nxt_stage2;

	always_comb begin
		nxt_stage1 = async_in;
		nxt_stage2 = stage1_ff;
	end

	// first stage feeds only the second
	always_ff @(posedge core_clk) begin
		if (rst) begin
			stage1_ff <= '0;
			stage2_ff <= '0;
		end else begin
			stage1_ff <= nxt_stage1;
			stage2_ff <= nxt_stage2;
		end
	end

	assign sync_out = stage2_ff;
endmodule

// ### src/asr_readout.sv
`timescale 1ns/100ps
module asr_readout #(
	parameter int CONV_CYCLES = asr_pkg::CONV_CYCLES
) (
	input  wire logic                   core_clk,
	input  wire logic                   rst,
	input  wire logic                   serial_clock,
	input  wire logic                   chip_select_n,
	input  wire logic                   read_enable_n,
	input  wire logic                   convert_start_n,
	input  wire logic                   chain_input_or_read_mode,
	input  wire logic                   clock_source_select,
	input  wire logic                   serial_parallel_select,
	input  wire logic [15:0]            sample_code,
	output logic                        serial_data_output,
	output logic                        serial_data_oe,
	output logic                        busy,
	output logic                        read_overrun_pulse
);
	localparam int CW = $clog2(CONV_CYCLES + 1);
	localparam logic [CW-1:0] CONV_LAST = CW'(CONV_CYCLES - 1);
	localparam logic [4:0] BITS_FULL = 5'(asr_pkg::RESULT_BITS);

	function automatic logic asr_fell(input logic now_lvl, input logic prev_lvl);
		return ~now_lvl & prev_lvl;
	endfunction

	function automatic logic asr_short_read(input logic [4:0] count);
		return count < BITS_FULL;
	endfunction

	asr_pkg::asr_pins_type pins_raw;
	asr_pkg::asr_pins_type pins_s;
	logic [4:0]            pins_bits;
	logic                  mode_s;
	logic                  ser_s;

	assign pins_raw = '{serial_clock: serial_clock, chip_select_n: chip_select_n,
		read_enable_n: read_enable_n, convert_start_n: convert_start_n,
		chain_input_or_read_mode: chain_input_or_read_mode};

	asr_sync #(.WIDTH(7)) u_sync (
		.core_clk (core_clk),
		.rst      (rst),
		.async_in ({pins_raw, clock_source_select, serial_parallel_select}),
		.sync_out ({pins_bits, mode_s, ser_s})
	);
	assign pins_s = asr_pkg::asr_pins_type'(pins_bits);

	// edge detect state on synchronised pins
	logic sclk_prev_ff;
	logic cnv_prev_ff;
	logic nxt_sclk_prev;
	logic nxt_cnv_prev;
	logic sclk_rise;
	logic sclk_fall;
	logic cnv_fall;
	logic frame_on;

	always_comb begin
		nxt_sclk_prev = pins_s.serial_clock;
		nxt_cnv_prev  = pins_s.convert_start_n;
		sclk_rise     = pins_s.serial_clock & ~sclk_prev_ff;
		sclk_fall     = asr_fell(pins_s.serial_clock, sclk_prev_ff);
		cnv_fall      = asr_fell(pins_s.convert_start_n, cnv_prev_ff);
		// chip-select and read-enable act as one or'd enable
		frame_on      = ~(pins_s.chip_select_n | pins_s.read_enable_n) & mode_s & ser_s;
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			// matches the synced pin's reset level, so reset makes no edge
			sclk_prev_ff <= 1'b0;
			// synced start reads low in reset; a 1 here would fake a fall
			cnv_prev_ff  <= 1'b0;
		end else begin
			sclk_prev_ff <= nxt_sclk_prev;
			cnv_prev_ff  <= nxt_cnv_prev;
		end
	end

	// conversion sequencer on core clock, stands in for the internal conversion clock
	typedef enum logic [0:0] {
		ASR_IDLE,
		ASR_CONV
	} asr_conv_type;

	function automatic logic asr_in_conv(input asr_conv_type state);
		return state == ASR_CONV;
	endfunction

	asr_conv_type  conv_state_ff;
	asr_conv_type  nxt_conv_state;
	logic [CW-1:0] conv_cnt_ff;
	logic [CW-1:0] nxt_conv_cnt;
	logic [15:0]   result_ff;
	logic [15:0]   nxt_result;
	logic          conv_done;

	always_comb begin
		nxt_conv_state = conv_state_ff;
		nxt_conv_cnt   = conv_cnt_ff;
		nxt_result     = result_ff;
		conv_done      = 1'b0;
		case (conv_state_ff)
			ASR_IDLE: begin
				if (cnv_fall) begin
					nxt_conv_state = ASR_CONV;
					nxt_conv_cnt   = '0;
				end
			end
			ASR_CONV: begin
				// a new falling start cannot restart a running conversion
				if (conv_cnt_ff == CONV_LAST) begin
					nxt_conv_state = ASR_IDLE;
					nxt_result     = sample_code;
					conv_done      = 1'b1;
				end else begin
					nxt_conv_cnt = conv_cnt_ff + CW'(1);
				end
			end
			default: begin
				nxt_conv_state = ASR_IDLE;
			end
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			conv_state_ff <= ASR_IDLE;
			conv_cnt_ff   <= '0;
			result_ff     <= asr_pkg::RESULT_RESET;
		end else begin
			conv_state_ff <= nxt_conv_state;
			conv_cnt_ff   <= nxt_conv_cnt;
			result_ff     <= nxt_result;
		end
	end

	// serial shifter: outputs move on host clock fall, chain input caught on rise
	logic [15:0] shreg_ff;
	logic [15:0] nxt_shreg;
	logic [4:0]  bitcnt_ff;
	logic [4:0]  nxt_bitcnt;
	logic        chain_bit_ff;
	logic        nxt_chain_bit;
	logic        during_ff;
	logic        nxt_during;
	logic        conv_busy;

	asr_pkg::asr_outs_type outs_ff;
	asr_pkg::asr_outs_type nxt_outs;

	always_comb begin
		conv_busy     = asr_in_conv(conv_state_ff);
		nxt_shreg     = shreg_ff;
		nxt_bitcnt    = bitcnt_ff;
		nxt_chain_bit = chain_bit_ff;
		nxt_during    = during_ff;
		nxt_outs      = outs_ff;

		if (frame_on && sclk_rise) begin
			nxt_chain_bit = pins_s.chain_input_or_read_mode;
		end

		// a read begun while busy is a read of the previous result
		if (frame_on && conv_busy && asr_short_read(bitcnt_ff)) begin
			nxt_during = 1'b1;
		end

		// host clock high and low must each last about three core periods
		// idle-high clock: its first fall already moves past the msb
		if (frame_on && sclk_fall) begin
			// works with a gated or free-running clock idling low
			if (during_ff || conv_busy) begin
				nxt_shreg = {shreg_ff[14:0], 1'b0};
			end else begin
				// chain bits are only let through after conversion
				// one stage per converter, so chain length is not limited here
				nxt_shreg = {shreg_ff[14:0], chain_bit_ff};
			end
			if (bitcnt_ff != BITS_FULL) begin
				nxt_bitcnt = bitcnt_ff + 5'h01;
			end
		end

		nxt_outs.read_overrun_pulse = 1'b0;
		if (conv_done) begin
			// fresh result reloads the shifter, msb first
			nxt_shreg  = nxt_result;
			nxt_bitcnt = asr_pkg::BITCNT_RESET;
			nxt_during = 1'b0;
			if (during_ff && asr_short_read(bitcnt_ff)) begin
				nxt_outs.read_overrun_pulse = 1'b1;
			end
		end

		nxt_outs.serial_data_output = nxt_shreg[15];
		nxt_outs.serial_data_oe     = frame_on;
		nxt_outs.busy               = asr_in_conv(nxt_conv_state);
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			shreg_ff     <= asr_pkg::RESULT_RESET;
			bitcnt_ff    <= BITS_FULL;
			chain_bit_ff <= 1'b0;
			during_ff    <= 1'b0;
			outs_ff      <= '0;
		end else begin
			shreg_ff     <= nxt_shreg;
			bitcnt_ff    <= nxt_bitcnt;
			chain_bit_ff <= nxt_chain_bit;
			during_ff    <= nxt_during;
			outs_ff      <= nxt_outs;
		end
	end

	assign serial_data_output = outs_ff.serial_data_output;
	assign serial_data_oe     = outs_ff.serial_data_oe;
	assign busy               = outs_ff.busy;
	assign read_overrun_pulse = outs_ff.read_overrun_pulse;
endmodule

// ### dv/asr_readout_properties.sv
`timescale 1ns/100ps
module asr_readout_checker #(
	parameter int CONV_CYCLES = 200
) (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic chip_select_n,
	input wire logic read_enable_n,
	input wire logic convert_start_n,
	input wire logic clock_source_select,
	input wire logic serial_parallel_select,
	input wire logic serial_data_oe,
	input wire logic busy,
	input wire logic read_overrun_pulse
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);
	logic [15:0] cnt_ff;
	logic        frame;
	assign frame = !chip_select_n && !read_enable_n && clock_source_select && serial_parallel_select;
	// counts busy cycles, far too many for a repetition
	always_ff @(posedge core_clk) cnt_ff <= (rst || !busy) ? 16'h0 : cnt_ff + 16'h1;
	desel_off_a: assert property ((chip_select_n | read_enable_n) [*5] |-> !serial_data_oe) else $error("oe");
	int_clk_off_a: assert property (!clock_source_select [*5] |-> !serial_data_oe) else $error("oe int");
	par_off_a: assert property (!serial_parallel_select [*5] |-> !serial_data_oe) else $error("oe par");
	frame_on_a: assert property (frame [*5] |-> serial_data_oe) else $error("no oe");
	conv_start_a: assert property ($fell(convert_start_n) && !busy |-> ##3 busy) else $error("no busy");
	busy_len_a: assert property ($fell(busy) |-> cnt_ff == 16'(CONV_CYCLES)) else $error("busy len");
	ovr_end_a: assert property (read_overrun_pulse |-> $fell(busy)) else $error("ovr time");
	ovr_once_a: assert property (read_overrun_pulse |=> !read_overrun_pulse) else $error("ovr len");
endmodule
bind asr_readout asr_readout_checker #(.CONV_CYCLES(CONV_CYCLES)) chk_u (.core_clk, .rst, .chip_select_n,
	.read_enable_n, .convert_start_n, .clock_source_select, .serial_parallel_select, .serial_data_oe, .busy,
	.read_overrun_pulse);

// ### dv/asr_host_model.sv
`timescale 1ns/100ps
module asr_host_model (
	output logic        serial_clock,
	output logic        chip_select_n,
	output logic        read_enable_n,
	output logic        chain_input_or_read_mode,
	input  wire logic   serial_data_output,
	input  wire logic   serial_data_oe,
	output logic [31:0] got,
	output logic        got_vld
);
	initial begin
		{serial_clock, chain_input_or_read_mode, got_vld} = 3'b000;
		{chip_select_n, read_enable_n} = 2'b11;
		got = 32'h0;
	end
	// clock idles low, runs only inside a frame
	// gated, but far below the advised 18 MHz: the core sampler caps it
	task automatic xfer(input int n, input logic [47:0] w, input logic hold);
		got = 32'h0;
		#53 {chip_select_n, read_enable_n} = 2'b00;
		#320;
		for (int k = 1; k <= n; k++) begin
			if (!hold)
				chain_input_or_read_mode = w[47-k];
			#160 serial_clock = 1'b1;
			// released line reads inverted, never a lucky match
			got = {got[30:0], serial_data_oe ? serial_data_output : ~serial_data_output};
			#160 serial_clock = 1'b0;
		end
		#320 {chip_select_n, read_enable_n} = 2'b11;
		if (!hold)
			chain_input_or_read_mode = ~chain_input_or_read_mode;
		got_vld = 1'b1;
		#40 got_vld = 1'b0;
	endtask
endmodule

// ### dv/testbench.sv
`timescale 1ns/100ps
module testbench;
	logic        core_clk = 1'b0, rst = 1'b1, convert_start_n = 1'b1, skip = 1'b0;
	logic [1:0]  sel = 2'b11;
	logic [15:0] sample_code = 16'h0000, code, prev;
	logic        serial_clock, chip_select_n, read_enable_n, chain_input_or_read_mode;
	logic        serial_data_output, serial_data_oe, busy, read_overrun_pulse, got_vld;
	logic [31:0] got, exp_q[$];
	logic [47:0] w;
	int          seed = 32'h2ba3, n_fail = 0, tests_run = 0, ovr_exp = 0;
	always #20 core_clk = ~core_clk;
	asr_readout #(.CONV_CYCLES(200)) dut_u (.core_clk, .rst, .serial_clock, .chip_select_n, .read_enable_n,
		.convert_start_n, .chain_input_or_read_mode, .clock_source_select(sel[1]),
		.serial_parallel_select(sel[0]), .sample_code, .serial_data_output, .serial_data_oe, .busy,
		.read_overrun_pulse);
	asr_host_model host_u (.serial_clock, .chip_select_n, .read_enable_n, .chain_input_or_read_mode,
		.serial_data_output, .serial_data_oe, .got, .got_vld);
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		tests_run++;
		if (s !== e) begin
			n_fail++;
			$display("CHECK FAILED %0t: saw %h want %h", $time, s, e);
		end
	endtask
	task automatic test_done;
		$display("failures %0d of %0d checks", n_fail, tests_run);
		if (n_fail == 0 && tests_run > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic start(input logic [15:0] c);
		@(negedge core_clk);
		sample_code = c;
		convert_start_n = 1'b0;
		repeat (4) @(negedge core_clk);
		convert_start_n = 1'b1;
	endtask
	task automatic fin;
		for (int i = 0; i < 400 && busy !== 1'b0; i++)
			@(negedge core_clk);
		repeat (4) @(negedge core_clk);
	endtask
	always @(posedge got_vld) if (!skip) chk(got, exp_q.pop_front());
	always @(negedge core_clk) if (read_overrun_pulse === 1'b1) begin
		chk(32'(ovr_exp), 32'h1);
		ovr_exp--;
	end
	initial begin
		#400000;
		n_fail++;
		test_done;
	end
	initial begin
		repeat (2) @(negedge core_clk);
		rst = 1'b0;
		repeat (4) @(negedge core_clk);
		w = {16'($random(seed)), 32'($random(seed))};
		code = 16'($random(seed));
		start(code);
		fin;
		exp_q.push_back({code, w[46:31]});
		host_u.xfer(32, w, 1'b0);
		code = 16'($random(seed));
		start(code);
		fin;
		// reads with the port disabled must not move the shifter
		skip = 1'b1;
		for (int m = 1; m <= 2; m++) begin
			@(negedge core_clk);
			sel = 2'(m);
			host_u.xfer(8, w, 1'b0);
		end
		@(negedge core_clk);
		sel = 2'b11;
		skip = 1'b0;
		for (int b = 1; b >= 0; b--) begin
			exp_q.push_back({24'h0, code[8*b+:8]});
			host_u.xfer(8, w, 1'b0);
		end
		prev = 16'($random(seed));
		start(prev);
		fin;
		for (int n = 16; n >= 8; n -= 8) begin
			code = 16'($random(seed));
			start(code);
			exp_q.push_back(32'(prev >> (16 - n)));
			ovr_exp += (n < 16);
			host_u.xfer(n, w, 1'b1);
			fin;
			prev = code;
		end
		chk(32'(ovr_exp), 32'h0);
		test_done;
	end
endmodule
